// ===== hw/fpc_ctrl.sv
// host controller that reads and fuse-programs the 2048x8 prom
`timescale 1ns/1ns
`default_nettype none
module fpc_ctrl
   import fpc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   // user request side
   input  wire logic              reqValid,
   input  wire fpc_req_s          req,
   output logic                   reqReady,
   output logic                   doneValid,
   output logic [DATA_W-1:0]      doneData,
   output logic                   doneFail,
   output logic [CNT_W-1:0]       donePulses,
   // prom pins
   output logic [ADDR_W-1:0]      promAddr,
   output fpc_sel_s               promSel,
   input  wire logic [DATA_W-1:0] promData,
   output logic [DATA_W-1:0]      burnDrive,
   output logic [DATA_W-1:0]      burnDriveEn,
   output logic                   senseEn
);
   //------------------------------------------------------------
   // reset release and pin synchronisation
   //------------------------------------------------------------
   logic              rstMeta;
   logic              rstSyncN;
   logic [DATA_W-1:0] dataSync;

   // reset enters asynchronously, leaves the logic through two flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   fpc_sync #(.W(DATA_W)) uDataSync (
      .mclk     (mclk),
      .rstSyncN (rstSyncN),
      .din      (promData),
      .dout     (dataSync)
   );

   //------------------------------------------------------------
   // sequencer
   //------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_RD_SETUP, S_RD_SAMPLE, S_PG_SETUP, S_PULSE,
      S_SENSE_WAIT, S_SENSE_HOLD, S_PG_HOLD, S_DONE
   } fpc_state_e;

   fpc_state_e        state;
   fpc_state_e        next_state;
   logic [CNT_W-1:0]  timer;
   logic [CNT_W-1:0]  next_timer;
   logic [CNT_W-1:0]  pulses;
   logic [2:0]        bitSel;
   logic              extraPhase;
   logic              fail;
   logic [DATA_W-1:0] capData;
   wire               timerDone = (timer == '0);
   wire               bitIsOne  = dataSync[bitSel];
   wire               limitHit  = (pulses >= MAX_PULSES_C);
   wire               senseEnd  = (state == S_SENSE_HOLD) && timerDone;

   // next state and timer reload
   // a state whose timer is loaded with n lasts n+1 cycles, so program
   // loads are one short; this keeps the duty cycle above its floor
   always_comb begin
      next_state = state;
      next_timer = timerDone ? '0 : timer - CNT_W'(1);
      case (state)
         S_IDLE: begin
            if (reqValid) begin
               // address comes first for programming; a read sets address and selects on the same edge
               next_state = req.prog ? S_PG_SETUP : S_RD_SETUP;
               next_timer = req.prog ? ADDR_C - CNT_W'(1) : SENSE_C;
            end
         end
         S_RD_SETUP: begin
            if (timerDone) next_state = S_RD_SAMPLE;
         end
         S_RD_SAMPLE: next_state = S_DONE;
         S_PG_SETUP: begin
            if (timerDone) begin
               next_state = S_PULSE;
               next_timer = PW_C - CNT_W'(1);
            end
         end
         S_PULSE: begin
            // width centred in its window
            if (timerDone) begin
               next_state = S_SENSE_WAIT;
               next_timer = SENSE_C - CNT_W'(1);
            end
         end
         S_SENSE_WAIT: begin
            // sense only after the settle time
            if (timerDone) begin
               next_state = S_SENSE_HOLD;
               next_timer = GAP_C - SENSE_C - CNT_W'(1);
            end
         end
         S_SENSE_HOLD: begin
            if (timerDone) begin
               // one extra pulse after first good sense, none if the limit is already hit
               if (extraPhase || limitHit) begin
                  next_state = S_PG_HOLD;
                  next_timer = ADDR_C - CNT_W'(1);
               end else begin
                  next_state = S_PULSE;
                  next_timer = PW_C - CNT_W'(1);
               end
            end
         end
         S_PG_HOLD: begin
            if (timerDone) next_state = S_DONE;
         end
         S_DONE: next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   // state, counters and captured data
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state      <= S_IDLE;
         timer      <= '0;
         pulses     <= '0;
         bitSel     <= '0;
         extraPhase <= 1'b0;
         fail       <= 1'b0;
         capData    <= '0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         if (state == S_IDLE && reqValid) begin
            bitSel     <= req.bitSel;
            pulses     <= '0;
            extraPhase <= 1'b0;
            fail       <= 1'b0;
         end
         if (state == S_PULSE && timerDone) begin
            pulses <= pulses + CNT_W'(1); // counted per bit
         end
         // decide at end of sensing: success arms the extra pulse
         if (state == S_SENSE_HOLD && timerDone && !extraPhase) begin
            if (bitIsOne) begin
               extraPhase <= 1'b1;
            end else if (limitHit) begin
               fail <= 1'b1; // give up at the limit
            end
         end
         // program keeps the last sensed word; pins float once sensing ends
         if (state == S_RD_SAMPLE || senseEnd) begin
            capData <= dataSync;
         end
      end
   end

   //------------------------------------------------------------
   // pin decode
   //------------------------------------------------------------
   // decodes use next_state so registered pins line up with the state
   wire        readSel  = (next_state == S_RD_SETUP)
                          || (next_state == S_RD_SAMPLE);
   wire        pulseOn  = (next_state == S_PULSE);
   wire        senseOn  = (next_state == S_SENSE_WAIT)
                          || (next_state == S_SENSE_HOLD);
   wire        loadAddr = (state == S_IDLE) && reqValid;
   wire [7:0]  bitMask  = 8'h01 << bitSel;
   // deselected: low-active select high, high-active selects low
   wire fpc_sel_s selOn    = fpc_sel_s'{1'b0, 1'b1, 1'b1};
   wire fpc_sel_s selOff   = fpc_sel_s'{1'b1, 1'b0, 1'b0};

   // registered pin drive; program keeps the device deselected
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         promAddr    <= '0;
         promSel     <= '{1'b1, 1'b0, 1'b0};
         burnDrive   <= '0;
         burnDriveEn <= '0;
         senseEn     <= 1'b0;
      end else begin
         if (loadAddr) promAddr <= req.addr; // held through hold
         // all three selects asserted only for reads
         promSel <= readSel ? selOn : selOff;
         // only the chosen bit line is pulsed
         burnDrive   <= pulseOn ? bitMask : '0;
         burnDriveEn <= pulseOn ? bitMask : '0;
         // sense current covers settle and hold
         senseEn     <= senseOn;
      end
   end

   // user side answers
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         reqReady   <= 1'b0;
         doneValid  <= 1'b0;
         doneData   <= '0;
         doneFail   <= 1'b0;
         donePulses <= '0;
      end else begin
         reqReady  <= (next_state == S_IDLE);
         doneValid <= (state == S_DONE);
         if (state == S_DONE) begin
            doneData   <= capData; // stored word
            doneFail   <= fail;
            donePulses <= pulses;
         end
      end
   end

endmodule
`default_nettype wire

// ===== hw/fpc_pkg.sv
// package for the fuse prom read/program controller
// Operation
// - read needs low-active select low and both high-active selects high.
// - eleven address lines pick one of 2048 words, shared by read/program.
// - set address first, then deselect the device before pulsing.
// - while deselected, pulse the single output bit that must become one.
// - once the bit senses as one, give exactly one extra pulse, stop; the code gives none if that sense follows pulse 10000.
// - never exceed 10000 pulses per bit; report failure at the limit.
// - each pulse lasts 7.1 to 7.9 us with duty cycle at least 70 percent.
// - address stable 10 us before programming and 10 us after it.
// - wait 0.7 us after a pulse before sensing, sense 0.7 us before next.
package fpc_pkg;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int CLK_KHZ = 20000;
   // times in nanoseconds
   localparam int PW_MIN_NS = 7100;
   localparam int PW_MAX_NS = 7900;
   localparam int ADDR_WAIT_NS = 10000;
   localparam int SENSE_WAIT_NS = 700;
   localparam int DUTY_MIN_PCT = 70;
   localparam int MAX_PULSES = 10000;
   localparam int EXTRA_PULSES = 1;
   // least times round up, pulse width aims at the middle of its window
   localparam int PW_CYC = ((PW_MIN_NS + PW_MAX_NS) / 2 * CLK_KHZ) / 1000000;
   localparam int ADDR_CYC = (ADDR_WAIT_NS * CLK_KHZ + 999999) / 1000000;
   localparam int SENSE_CYC = (SENSE_WAIT_NS * CLK_KHZ + 999999) / 1000000;
   // gap after a pulse: at least both sense waits, and duty >= 70 percent
   localparam int GAP_RAW = (PW_CYC * (100 - DUTY_MIN_PCT)) / DUTY_MIN_PCT;
   localparam int GAP_CYC = (GAP_RAW > 2 * SENSE_CYC) ? GAP_RAW : 2 * SENSE_CYC;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] MAX_PULSES_C = CNT_W'(MAX_PULSES);
   localparam logic [CNT_W-1:0] PW_C = CNT_W'(PW_CYC);
   localparam logic [CNT_W-1:0] ADDR_C = CNT_W'(ADDR_CYC);
   localparam logic [CNT_W-1:0] SENSE_C = CNT_W'(SENSE_CYC);
   localparam logic [CNT_W-1:0] GAP_C = CNT_W'(GAP_CYC);

   typedef enum logic [1:0] {
      FPC_OP_READ,
      FPC_OP_PROG
   } fpc_op_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [2:0]        bitSel;
      logic              prog;
   } fpc_req_s;

   typedef struct packed {
      logic              selActiveLow;
      logic              selActiveHighA;
      logic              selActiveHighB;
   } fpc_sel_s;
endpackage

// ===== hw/fpc_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none
module fpc_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rstSyncN,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;

   // first stage is read only by the second
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule
`default_nettype wire

// ===== dv/fpc_ctrl_asserts.sv
// port checks for the fuse prom controller
`timescale 1ns/1ns
`default_nettype none
module fpc_ctrl_asserts
   import fpc_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic              reqValid,
   input wire fpc_req_s          req,
   input wire logic              reqReady,
   input wire logic              doneValid,
   input wire logic [CNT_W-1:0]  donePulses,
   input wire logic [ADDR_W-1:0] promAddr,
   input wire fpc_sel_s          promSel,
   input wire logic [DATA_W-1:0] burnDriveEn,
   input wire logic [DATA_W-1:0] burnDrive,
   input wire logic              senseEn
);
   logic [15:0]       pw;
   logic [15:0]       gap;
   logic [15:0]       addrAge;
   logic [15:0]       burnAge;
   logic [15:0]       seen;
   logic [15:0]       lastPw;
   logic [ADDR_W-1:0] prevA;
   wire burn = |burnDriveEn;
   wire on = !promSel.selActiveLow & promSel.selActiveHighA
             & promSel.selActiveHighB;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // cycle ages; only the hold age saturates, runs stay short
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pw <= '0;
         gap <= '0;
         addrAge <= '0;
         burnAge <= 16'hFFFF;
         seen <= '0;
         lastPw <= '0;
         prevA <= '0;
      end else begin
         // width of the pulse that just ended, for the duty check
         if (!burn && pw != 16'h0) lastPw <= pw;
         prevA <= promAddr;
         pw <= burn ? pw + 16'h1 : 16'h0;
         gap <= burn ? 16'h0 : gap + 16'h1;
         addrAge <= (promAddr != prevA) ? 16'h0 : addrAge + 16'h1;
         burnAge <= burn ? 16'h0 : burnAge + {15'h0, ~&burnAge};
         if (reqValid && reqReady) seen <= '0;
         else if (burn && pw == 16'h0) seen <= seen + 16'h1;
      end
   end
   property p_burn_desel;
      burn |-> !on && $stable(promAddr);
   endproperty
   a_burn_desel: assert property (p_burn_desel)
      else $error("burn pulse while selected or address moving");
   property p_burn_bit;
      burn |-> $onehot(burnDriveEn);
   endproperty
   a_burn_bit: assert property (p_burn_bit)
      else $error("burn pulse on more than one output");
   property p_width;
      $fell(burn) |-> pw >= 16'd142 && pw <= 16'd158;
   endproperty
   a_width: assert property (p_width)
      else $error("burn pulse width out of window");
   property p_gap;
      $rose(burn) && gap < 16'd150 |-> gap >= 16'd28
         && 16'd7 * gap <= 16'd3 * lastPw;
   endproperty
   a_gap: assert property (p_gap)
      else $error("gap between pulses breaks sense time or duty");
   property p_drive;
      burn |-> burnDrive == burnDriveEn && !senseEn;
   endproperty
   a_drive: assert property (p_drive)
      else $error("burn data differs from enable or sense during pulse");
   property p_setup;
      $rose(burn) |-> addrAge >= 16'd199;
   endproperty
   a_setup: assert property (p_setup)
      else $error("address setup before pulsing too short");
   property p_hold;
      $changed(promAddr) |-> burnAge >= 16'd199;
   endproperty
   a_hold: assert property (p_hold)
      else $error("address hold after pulsing too short");
   property p_read;
      reqValid && reqReady && !req.prog |-> ##[1:3] on;
   endproperty
   a_read: assert property (p_read)
      else $error("read did not select the device");
   property p_count;
      doneValid && seen != 0 |-> donePulses == seen && seen <= 16'd10001;
   endproperty
   a_count: assert property (p_count)
      else $error("reported pulse count differs from pulses seen");
   c_prog: cover property (doneValid && seen > 16'h1);
   c_pulse: cover property ($rose(burn));
   c_read: cover property (reqValid && reqReady && !req.prog);
endmodule
`default_nettype wire

// ===== dv/fpc_prom_model.sv
// behavioural 2048x8 fuse prom with slow-blowing fuses
`timescale 1ns/1ns
`default_nettype none
module fpc_prom_model
   import fpc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic [ADDR_W-1:0] promAddr,
   input  wire fpc_sel_s          promSel,
   input  wire logic [DATA_W-1:0] burnDriveEn,
   input  wire logic              senseEn,
   input  wire logic [3:0]        need,
   output logic      [DATA_W-1:0] promData
);
   logic [DATA_W-1:0]       mem [2**ADDR_W];
   logic [DATA_W-1:0][3:0]  cnt = '0;
   logic [DATA_W-1:0]       last = 8'h00;
   logic [DATA_W-1:0]       prevEn = 8'h00;
   logic [ADDR_W-1:0]       prevA = '0;
   wire on = !promSel.selActiveLow & promSel.selActiveHighA
             & promSel.selActiveHighB;
   // unprogrammed fuses read zero
   initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 8'h00;
   // released outputs toggle so a stale value never looks valid
   assign promData = (on || senseEn) ? mem[promAddr] : ~last;
   // a fuse blows only after need pulses at one address
   always @(posedge mclk) begin
      last <= promData;
      prevEn <= burnDriveEn;
      prevA <= promAddr;
      for (int b = 0; b < DATA_W; b++) begin
         if (promAddr != prevA) cnt[b] <= 4'h0;
         else if (!on && burnDriveEn[b] && !prevEn[b]) begin
            cnt[b] <= cnt[b] + 4'h1;
            if (cnt[b] + 4'h1 >= need) mem[promAddr][b] <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/fpc_ctrl_test.sv
// self-checking bench for the fuse prom controller
`timescale 1ns/1ns
`default_nettype none
module fpc_ctrl_test
   import fpc_pkg::*;
;
   logic              mclk = 1'b0;
   logic              rstn = 1'b0;
   logic              reqValid = 1'b0;
   fpc_req_s          req = '0;
   logic [3:0]        need = 4'h1;
   logic              reqReady, doneValid, doneFail, senseEn;
   logic [DATA_W-1:0] doneData, promData, burnDrive, burnDriveEn;
   logic [CNT_W-1:0]  donePulses;
   logic [ADDR_W-1:0] promAddr, a;
   logic [2:0]        b;
   fpc_sel_s          promSel;
   logic [DATA_W-1:0] shadow [2**ADDR_W];
   int                nMismatch = 0;
   int                totalChecks = 0;
   int                cycles = 0;
   always #25 mclk = ~mclk;
   fpc_ctrl dut_u (.mclk, .rstn, .reqValid, .req, .reqReady, .doneValid,
      .doneData, .doneFail, .donePulses, .promAddr, .promSel, .promData,
      .burnDrive, .burnDriveEn, .senseEn);
   fpc_prom_model prom_u (.mclk, .promAddr, .promSel, .burnDriveEn,
      .senseEn, .need, .promData);
   task automatic chk(input string what, input logic [15:0] exp, got);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // a bit already blown senses one after the first pulse, then one more
   function automatic logic [15:0] expPulses(input logic [3:0] nd,
                                             input logic was);
      return was ? 16'h2 : 16'(nd) + 16'h1;
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one request, held until taken, then its answer checked
   task automatic op(input logic p, input logic [ADDR_W-1:0] ad,
                     input logic [2:0] bi);
      int n;
      logic was;
      was = shadow[ad][bi];
      @(negedge mclk);
      // ready is settled at the falling edge, the next rising edge takes
      while (reqReady !== 1'b1) @(negedge mclk);
      reqValid = 1'b1;
      req = '{addr: ad, bitSel: bi, prog: p};
      @(negedge mclk);
      reqValid = 1'b0;
      n = 0;
      while (doneValid !== 1'b1 && n < 4000) begin
         @(negedge mclk);
         n++;
      end
      chk("done", 16'h1, 16'(doneValid));
      if (p) begin
         chk("pulses", expPulses(need, was), donePulses);
         shadow[ad][bi] = 1'b1;
         chk("fail", 16'h0, 16'(doneFail));
         chk("bit", 16'h1, 16'(doneData[bi]));
         chk("word", 16'(shadow[ad]), 16'(doneData));
      end else chk("data", 16'(shadow[ad]), 16'(doneData));
   endtask
   // hang guard well above the expected run length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         nMismatch++;
         results();
      end
   end
   initial begin
      for (int i = 0; i < 2**ADDR_W; i++) shadow[i] = 8'h00;
      void'($urandom(32'h496e4a64));
      repeat (20) @(posedge mclk);
      @(negedge mclk) rstn = 1'b1;
      op(1'b0, 11'h000, 3'h0);
      op(1'b0, 11'h7FF, 3'h0);
      $display("test blank reads done");
      op(1'b1, 11'h7FF, 3'h7);
      need = 4'h3;
      op(1'b1, 11'h7FF, 3'h0);
      op(1'b0, 11'h7FF, 3'h0);
      $display("test corner burns done");
      for (int k = 0; k < 6; k++) begin
         a = 11'($urandom_range(2047));
         b = 3'($urandom_range(7));
         need = 4'($urandom_range(5, 1));
         op(1'b1, a, b);
         op(1'b0, a, b);
      end
      $display("test random burns done");
      results();
   end
endmodule
bind fpc_ctrl fpc_ctrl_asserts chk_u (.mclk, .rstn, .reqValid, .req,
   .reqReady, .doneValid, .donePulses, .promAddr, .promSel, .burnDriveEn,
   .burnDrive, .senseEn);
`default_nettype wire
